// File: logic/dps_pkg.sv
package dps_pkg;
   // clock and time figures
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned MCLK_STOP_NS = 1000;
   // least time, so round up
   localparam int unsigned MCLK_STOP_CYC = (MCLK_STOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // latencies in frame periods, then the zero-run length in samples
   localparam int unsigned PWOFF_ENTER_FS = 4;
   localparam int unsigned PWOFF_LEAVE_FS = 1;
   localparam int unsigned RST_ASSERT_FS = 3;
   localparam int unsigned RST_RELEASE_FS = 2;
   localparam int unsigned ZF_RELEASE_FS = 2;
   localparam int unsigned FORCE_ZERO_FS = 2;
   localparam int unsigned ZERO_RUN_LEN = 8192;
   // alignment window, 4/256 of a frame either side of the edge
   localparam int unsigned SYNC_TOL_NUM = 4;
   localparam int unsigned SYNC_TOL_DEN = 256;
   localparam int unsigned DIV_LEN_DEF = 256;
   // register port
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned SAMP_W = 32;
   localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] REG_STAT = 4'h1;
   localparam logic [DATA_W-1:0] CTRL_RST = 16'h0006;
   // pin slots in the synchroniser
   localparam int unsigned PIN_PDN = 0;
   localparam int unsigned PIN_MCLK = 1;
   localparam int unsigned PIN_FRAME = 2;
   localparam int unsigned PIN_WORD = 3;
   localparam int unsigned PIN_N = 4;

   typedef enum logic [4:0] {
      ST_PDOWN = 5'h01,
      ST_MSTOP = 5'h02,
      ST_POFF = 5'h04,
      ST_RESET = 5'h08,
      ST_NORMAL = 5'h10
   } dps_state_t;

   typedef struct packed {
      logic [7:0] rsvd;
      logic zero_flag_polarity;
      logic zero_flag_mode;
      logic zero_flag_enable;
      logic frame_falling;
      logic external_filter_mode;
      logic sync_enable_bit;
      logic power_on_bit;
      logic soft_reset_n_bit;
   } dps_ctrl_t;

   typedef struct packed {
      logic [4:0] rsvd;
      logic mclk_present;
      logic sync_valid;
      logic zero_right;
      logic zero_left;
      logic internal_reset_n;
      logic power_eff;
      dps_state_t state;
   } dps_stat_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } dps_bus_req_t;

   typedef struct packed {
      logic valid;
      logic [SAMP_W-1:0] left;
      logic [SAMP_W-1:0] right;
   } dps_samp_t;

   typedef struct packed {
      logic digital_run;
      logic analog_run;
      logic analog_float;
      logic analog_common;
      logic data_force_zero;
      logic internal_reset_n;
   } dps_pwr_t;
endpackage

// File: logic/dps_power_seq.sv
// What this block does
// - power state chosen from pin, master clock, power and soft-reset bits
// - master clock silent 1us with pin high stops circuits, floats outputs
// - master clock return resumes normal operation when both bits are one
// - zero detect disabled while master clock is stopped
// - power bit zero stops circuits, floats outputs, registers stay reachable
// - zero detect keeps working during power-off by the power bit
// - power-off entered 4~5 frames after clear, left 1~2 after set
// - soft reset clears digital logic except registers and divider
// - internal reset asserts 3~4 frames after clear, releases 2~3 after set
// - zero flags rise with soft-reset clear, fall 2 frames after release
// - divider counter reset keeps internal edge near external edge
// - sync valid after 8192 zero samples on both channels or in soft reset
// - align to frame rise, frame fall in alternate format, word rise
// - sync enable bit zero disables synchronisation entirely
// - after 8192 zero samples both zero flags go high
// - internal data forced to zero for 2 frames after a counter reset
// - no counter reset when already aligned
// - sync valid at once when soft-reset bit is written zero
// - pin low stops and initialises everything, outputs float
// - pin low returns every control register to default
`timescale 1ns/1ns

// delays a control bit by whole frame periods, separate rise and fall
module dps_fs_delay #(
   parameter int unsigned RISE_FS = 1,
   parameter int unsigned FALL_FS = 1,
   parameter bit RST_VAL = 1'b0
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic clr,
   // frame tick and request
   input wire logic fs_tick,
   input wire logic target,
   // delayed level
   output logic eff_q
);
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic eff_d;
   logic [3:0] limit;

   if (RISE_FS < 1 || RISE_FS > 14 || FALL_FS < 1 || FALL_FS > 14) begin : g_bad
      $error("dps_fs_delay: frame counts must be 1..14");
   end

   // the first tick closes a partial frame, so N+1 ticks span N to N+1 frames
   assign limit = target ? 4'(RISE_FS + 1) : 4'(FALL_FS + 1);
   assign cnt_d = (target == eff_q) ? 4'h0 : (fs_tick ? cnt_q + 4'h1 : cnt_q);
   assign eff_d = (target != eff_q && cnt_d == limit) ? target : eff_q;

   // counter restarts when the request flips back
   always_ff @(posedge sys_clk) begin
      if (clr) begin
         cnt_q <= 4'h0;
         eff_q <= RST_VAL;
      end else begin
         cnt_q <= (eff_d == target) ? 4'h0 : cnt_d;
         eff_q <= eff_d;
      end
   end
endmodule

module dps_power_seq
   import dps_pkg::*;
#(
   parameter int unsigned DIV_LEN = dps_pkg::DIV_LEN_DEF,
   parameter int unsigned ZERO_RUN = dps_pkg::ZERO_RUN_LEN
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // device pins
   input wire logic powerdown_pin_n,
   input wire logic master_clock,
   input wire logic frame_clock,
   input wire logic ext_filter_word_clock,
   // register port
   input wire dps_pkg::dps_bus_req_t bus_req,
   output logic [dps_pkg::DATA_W-1:0] bus_rdata,
   // audio samples
   input wire dps_pkg::dps_samp_t samp,
   // power and analog control
   output dps_pkg::dps_pwr_t pwr_out,
   // zero flags and divider
   output logic zero_flag_left,
   output logic zero_flag_right,
   output logic internal_divided_clock,
   output logic divider_resync
);
   import dps_pkg::*;

   localparam int unsigned DIV_W = $clog2(DIV_LEN);
   localparam int unsigned TOL = DIV_LEN * SYNC_TOL_NUM / SYNC_TOL_DEN;
   localparam int unsigned RUN_W = $clog2(ZERO_RUN + 1);
   localparam int unsigned MC_W = $clog2(MCLK_STOP_CYC + 1);

   if (DIV_LEN < SYNC_TOL_DEN / SYNC_TOL_NUM || ZERO_RUN < 1) begin : g_bad
      $error("dps_power_seq: DIV_LEN too short or ZERO_RUN zero");
   end

   // pin synchroniser, three stages, a change counts once stages 2 and 3 agree
   logic [PIN_N-1:0] s1_q;
   logic [PIN_N-1:0] s2_q;
   logic [PIN_N-1:0] s3_q;
   logic [PIN_N-1:0] pin_q;
   logic [PIN_N-1:0] pin_prev_q;
   logic [PIN_N-1:0] pin_raw;
   logic [PIN_N-1:0] pin_d;
   assign pin_raw = {ext_filter_word_clock, frame_clock, master_clock, powerdown_pin_n};
   assign pin_d = (s2_q == s3_q) ? s3_q : pin_q;

   // pin edges read the agreed level only
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         pin_q <= '0;
         pin_prev_q <= '0;
      end else begin
         s1_q <= pin_raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         pin_q <= pin_d;
         pin_prev_q <= pin_q;
      end
   end

   // the power-down pin acts as the hard reset
   logic pin_up;
   logic hard_rst;
   logic [PIN_N-1:0] pin_rise;
   logic [PIN_N-1:0] pin_fall;
   assign pin_up = pin_q[PIN_PDN];
   assign hard_rst = !rst_b || !pin_up;
   assign pin_rise = pin_q & ~pin_prev_q;
   assign pin_fall = ~pin_q & pin_prev_q;

   // control register
   dps_ctrl_t ctrl_q;
   dps_ctrl_t ctrl_d;
   logic wr_ctrl;
   assign wr_ctrl = bus_req.wr && bus_req.addr == REG_CTRL;
   assign ctrl_d = wr_ctrl ? dps_ctrl_t'(bus_req.wdata & 16'h00FF) : ctrl_q;

   // defaults on pin low
   // writes are refused while the pin holds the device down
   always_ff @(posedge sys_clk) begin
      if (hard_rst) begin
         ctrl_q <= dps_ctrl_t'(CTRL_RST);
      end else begin
         ctrl_q <= ctrl_d;
      end
   end

   // master clock watchdog
   logic [MC_W-1:0] mc_cnt_q;
   logic mclk_ok_q;
   logic mclk_edge;
   logic mc_expire;
   assign mclk_edge = pin_rise[PIN_MCLK] || pin_fall[PIN_MCLK];
   assign mc_expire = mc_cnt_q == MC_W'(MCLK_STOP_CYC - 1);

   always_ff @(posedge sys_clk) begin
      if (hard_rst) begin
         mc_cnt_q <= '0;
         mclk_ok_q <= 1'b0;
      end else if (mclk_edge) begin
         mc_cnt_q <= '0;
         mclk_ok_q <= 1'b1;
      end else begin
         mc_cnt_q <= mc_expire ? mc_cnt_q : mc_cnt_q + MC_W'(1);
         mclk_ok_q <= mclk_ok_q && !mc_expire;
      end
   end

   // frame tick from the active interface
   logic ext_tick;
   logic fs_tick;
   assign ext_tick = ctrl_q.external_filter_mode ? pin_rise[PIN_WORD] :
                     ctrl_q.frame_falling ? pin_fall[PIN_FRAME] : pin_rise[PIN_FRAME];
   assign fs_tick = ext_tick && mclk_ok_q;

   logic pw_eff;
   dps_fs_delay #(
      .RISE_FS(PWOFF_LEAVE_FS),
      .FALL_FS(PWOFF_ENTER_FS),
      .RST_VAL(1'b1)
   ) u_pw_dly (
      .sys_clk(sys_clk),
      .clr(hard_rst),
      .fs_tick(fs_tick),
      .target(ctrl_q.power_on_bit),
      .eff_q(pw_eff)
   );

   logic int_rst_n;
   dps_fs_delay #(
      .RISE_FS(RST_RELEASE_FS),
      .FALL_FS(RST_ASSERT_FS),
      .RST_VAL(1'b0)
   ) u_rst_dly (
      .sys_clk(sys_clk),
      .clr(hard_rst),
      .fs_tick(fs_tick),
      .target(ctrl_q.soft_reset_n_bit),
      .eff_q(int_rst_n)
   );

   // power state
   dps_state_t state_q;
   dps_state_t state_d;
   assign state_d = !pin_up ? ST_PDOWN :
                    !mclk_ok_q ? ST_MSTOP :
                    !pw_eff ? ST_POFF :
                    !int_rst_n ? ST_RESET : ST_NORMAL;

   always_ff @(posedge sys_clk) begin
      if (hard_rst) begin
         state_q <= ST_PDOWN;
      end else begin
         state_q <= state_d;
      end
   end

   // zero-run counters, one per channel
   logic [1:0] run_hit;
   logic [1:0] samp_zero;
   assign samp_zero = {samp.right == '0, samp.left == '0};
   for (genvar ch = 0; ch < 2; ch++) begin : g_run
      logic [RUN_W-1:0] run_q;
      always_ff @(posedge sys_clk) begin
         if (hard_rst || !mclk_ok_q || !int_rst_n) begin
            run_q <= '0;
         end else if (samp.valid) begin
            run_q <= !samp_zero[ch] ? '0 :
                     (run_q == RUN_W'(ZERO_RUN)) ? run_q : run_q + RUN_W'(1);
         end
      end
      assign run_hit[ch] = run_q == RUN_W'(ZERO_RUN);
   end

   // flag held high from soft-reset clear to 2 frames past release
   logic zf_rst_q;
   logic [1:0] zrel_q;

   // flag release timing
   // the set term is checked first so a fresh clear is never lost
   always_ff @(posedge sys_clk) begin
      if (hard_rst) begin
         zf_rst_q <= 1'b1;
         zrel_q <= '0;
      end else if (!ctrl_q.soft_reset_n_bit) begin
         zf_rst_q <= 1'b1;
         zrel_q <= '0;
      end else if (zf_rst_q && int_rst_n) begin
         zrel_q <= fs_tick ? zrel_q + 2'h1 : zrel_q;
         zf_rst_q <= !(fs_tick && zrel_q == 2'(ZF_RELEASE_FS - 1));
      end
   end

   // raw flags per channel
   logic zl_raw;
   logic zr_raw;
   logic zl_out;
   logic zr_out;
   logic zf_on;
   assign zl_raw = zf_rst_q || run_hit[0];
   assign zr_raw = zf_rst_q || run_hit[1];
   assign zf_on = ctrl_q.zero_flag_enable && mclk_ok_q;
   // mode bit reports both channels jointly on each pin
   assign zl_out = zf_on && ((ctrl_q.zero_flag_mode ? zl_raw && zr_raw : zl_raw) ^ ctrl_q.zero_flag_polarity);
   assign zr_out = zf_on && ((ctrl_q.zero_flag_mode ? zl_raw && zr_raw : zr_raw) ^ ctrl_q.zero_flag_polarity);

   // divider counter and synchronisation
   logic [DIV_W-1:0] div_q;
   logic [DIV_W-1:0] div_wrap;
   logic sync_valid;
   logic aligned;
   logic resync;
   assign sync_valid = ctrl_q.sync_enable_bit && mclk_ok_q &&
                       (!ctrl_q.soft_reset_n_bit || (run_hit[0] && run_hit[1]));
   assign aligned = div_q < DIV_W'(TOL) || div_q >= DIV_W'(DIV_LEN - TOL);
   assign resync = ext_tick && sync_valid && !aligned;
   assign div_wrap = (div_q == DIV_W'(DIV_LEN - 1)) ? '0 : div_q + DIV_W'(1);

   // divider survives soft reset, only the pin and clock stop touch it
   always_ff @(posedge sys_clk) begin
      if (hard_rst || !mclk_ok_q) begin
         div_q <= '0;
      end else begin
         // the edge cycle itself stands for count zero
         div_q <= resync ? DIV_W'(1) : div_wrap;
      end
   end

   // forced-zero window after a counter reset
   logic [1:0] fz_q;
   always_ff @(posedge sys_clk) begin
      if (hard_rst) begin
         fz_q <= '0;
      end else if (resync) begin
         fz_q <= 2'(FORCE_ZERO_FS);
      end else if (fs_tick && fz_q != '0) begin
         fz_q <= fz_q - 2'h1;
      end
   end

   // registered outputs follow the next state, so run and reset never disagree
   dps_pwr_t pwr_d;
   assign pwr_d.digital_run = state_d == ST_NORMAL;
   assign pwr_d.analog_run = state_d == ST_NORMAL || state_d == ST_RESET;
   assign pwr_d.analog_float = !(state_d == ST_NORMAL || state_d == ST_RESET);
   assign pwr_d.analog_common = state_d == ST_RESET;
   assign pwr_d.data_force_zero = state_d != ST_NORMAL || fz_q != '0;
   assign pwr_d.internal_reset_n = int_rst_n;

   always_ff @(posedge sys_clk) begin
      if (hard_rst) begin
         pwr_out <= '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
         zero_flag_left <= 1'b0;
         zero_flag_right <= 1'b0;
         internal_divided_clock <= 1'b0;
         divider_resync <= 1'b0;
      end else begin
         pwr_out <= pwr_d;
         zero_flag_left <= zl_out;
         zero_flag_right <= zr_out;
         internal_divided_clock <= div_q < DIV_W'(DIV_LEN / 2);
         divider_resync <= resync;
      end
   end

   // status and read port, data stands one cycle after the strobe
   dps_stat_t stat;
   logic [DATA_W-1:0] rd_sel;
   assign stat.rsvd = '0;
   assign stat.mclk_present = mclk_ok_q;
   assign stat.sync_valid = sync_valid;
   assign stat.zero_right = zr_raw;
   assign stat.zero_left = zl_raw;
   assign stat.internal_reset_n = int_rst_n;
   assign stat.power_eff = pw_eff;
   assign stat.state = state_q;
   assign rd_sel = (bus_req.addr == REG_CTRL) ? DATA_W'(ctrl_q) :
                   (bus_req.addr == REG_STAT) ? DATA_W'(stat) : '0;

   // reads stay live in power-off; unmapped addresses answer zero
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         bus_rdata <= '0;
      end else begin
         bus_rdata <= bus_req.rd ? rd_sel : '0;
      end
   end
endmodule

// File: verification/dps_host_model.sv
`timescale 1ns/1ns
// host side: master clock, frame clock and word clock, all locked to sys_clk
module dps_host_model #(
   parameter int unsigned DIV_LEN = 64
) (
   // clock
   input wire logic sys_clk,
   // bench controls
   input wire logic stop,
   input wire logic jump,
   // clocks toward the device
   output logic master_clock,
   output logic frame_clock,
   output logic ext_filter_word_clock,
   // frame position seen by the bench
   output logic [15:0] phase
);
   logic [1:0] mdiv_q;
   initial begin
      mdiv_q = 2'h0;
      phase = 16'h0000;
   end
   // a stop freezes every clock, the way a host halts its clock tree
   always @(posedge sys_clk) begin
      if (!stop) begin
         mdiv_q <= mdiv_q + 2'h1;
         phase <= 16'((32'(phase) + (jump ? DIV_LEN / 2 : 1)) % DIV_LEN);
      end
   end
   // frame high in first half; word clock leads by a quarter frame
   assign master_clock = mdiv_q[1];
   assign frame_clock = 32'(phase) < DIV_LEN / 2;
   assign ext_filter_word_clock = ((32'(phase) + DIV_LEN / 4) % DIV_LEN) < DIV_LEN / 2;
endmodule

// File: verification/dps_power_seq_checker.sv
`timescale 1ns/1ns
module dps_power_seq_checker
   import dps_pkg::*;
#(
   parameter int unsigned DIV_LEN = 256,
   parameter int unsigned ZERO_RUN = 8192
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // pins and register port
   input wire logic powerdown_pin_n,
   input wire logic master_clock,
   input wire dps_pkg::dps_bus_req_t bus_req,
   input wire logic [dps_pkg::DATA_W-1:0] bus_rdata,
   // watched outputs
   input wire dps_pkg::dps_pwr_t pwr_out,
   input wire logic zero_flag_left,
   input wire logic zero_flag_right,
   input wire logic internal_divided_clock,
   input wire logic divider_resync
);
   logic mclk_q;
   logic [7:0] idle_q;
   // cycles since last master clock edge, raw pin so sync lag is slack
   always_ff @(posedge sys_clk) begin
      mclk_q <= master_clock;
      if (!rst_b || master_clock != mclk_q) begin
         idle_q <= 8'h00;
      end else if (idle_q != 8'hFF) begin
         idle_q <= idle_q + 8'h01;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   sequence s_pin_low;
      !powerdown_pin_n [*8];
   endsequence
   sequence s_quiet;
      idle_q >= 8'h70;
   endsequence
   property p_pdown;
      s_pin_low |-> pwr_out.analog_float && !pwr_out.analog_run && !zero_flag_left && !zero_flag_right;
   endproperty
   a_pdown: assert property (p_pdown) else $error("power down not held");
   property p_mstop;
      s_quiet |-> pwr_out.analog_float && !pwr_out.digital_run;
   endproperty
   a_mstop: assert property (p_mstop) else $error("clock stop not floating");
   property p_mstop_flags;
      s_quiet |-> !zero_flag_left && !zero_flag_right;
   endproperty
   a_mstop_flags: assert property (p_mstop_flags) else $error("zero flag during clock stop");
   property p_run;
      pwr_out.digital_run |-> pwr_out.internal_reset_n && pwr_out.analog_run && !pwr_out.analog_common;
   endproperty
   a_run: assert property (p_run) else $error("run with reset or common");
   property p_float;
      pwr_out.analog_float |-> !pwr_out.analog_run && !pwr_out.analog_common;
   endproperty
   a_float: assert property (p_float) else $error("float while driving");
   property p_common;
      $fell(pwr_out.internal_reset_n) && !pwr_out.analog_float |-> ##[0:3] pwr_out.analog_common;
   endproperty
   a_common: assert property (p_common) else $error("reset without common level");
   property p_rdata;
      !bus_req.rd |=> bus_rdata == 16'h0000;
   endproperty
   a_rdata: assert property (p_rdata) else $error("read data without read");
   property p_pulse;
      divider_resync |=> !divider_resync;
   endproperty
   a_pulse: assert property (p_pulse) else $error("resync repeated");
   property p_zero;
      divider_resync |-> ##[0:2] pwr_out.data_force_zero;
   endproperty
   a_zero: assert property (p_zero) else $error("no force zero on resync");
   property p_align;
      divider_resync |-> ##[0:1] internal_divided_clock;
   endproperty
   a_align: assert property (p_align) else $error("divider not restarted");
endmodule
bind dps_power_seq dps_power_seq_checker #(.DIV_LEN(DIV_LEN), .ZERO_RUN(ZERO_RUN)) u_dps_power_seq_checker (
   .sys_clk(sys_clk), .rst_b(rst_b), .powerdown_pin_n(powerdown_pin_n), .master_clock(master_clock),
   .bus_req(bus_req), .bus_rdata(bus_rdata), .pwr_out(pwr_out), .zero_flag_left(zero_flag_left),
   .zero_flag_right(zero_flag_right), .internal_divided_clock(internal_divided_clock),
   .divider_resync(divider_resync)
);

// File: verification/tb.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
   $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tb;
   import dps_pkg::*;
   localparam int D = 64;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic powerdown_pin_n = 1'b1;
   logic stop = 1'b0;
   logic jump = 1'b0;
   logic master_clock, frame_clock, ext_filter_word_clock, zero_flag_left, zero_flag_right;
   logic internal_divided_clock, divider_resync;
   logic [15:0] phase;
   logic [DATA_W-1:0] bus_rdata, d;
   dps_bus_req_t bus_req = '0;
   dps_samp_t samp = '0;
   dps_pwr_t pwr_out;
   logic [31:0] sval = 32'h1;
   logic [3:0] scnt = 4'h0;
   logic [15:0] modes [3] = '{16'h0027, 16'h002F, 16'h0037};
   int edges [3] = '{0, 3 * D / 4, D / 2};
   int n_errors = 0;
   int checks_done = 0;
   int cyc = 0;
   int n_rs = 0;
   int n, m, k;

   initial begin
      forever #5 sys_clk = ~sys_clk;
   end
   dps_host_model #(.DIV_LEN(D)) u_dps_host_model (.sys_clk(sys_clk), .stop(stop), .jump(jump),
      .master_clock(master_clock), .frame_clock(frame_clock),
      .ext_filter_word_clock(ext_filter_word_clock), .phase(phase));
   // short divider and zero run keep the run brief
   dps_power_seq #(.DIV_LEN(D), .ZERO_RUN(4)) u_dps_power_seq (.sys_clk(sys_clk), .rst_b(rst_b),
      .powerdown_pin_n(powerdown_pin_n), .master_clock(master_clock), .frame_clock(frame_clock),
      .ext_filter_word_clock(ext_filter_word_clock), .bus_req(bus_req), .bus_rdata(bus_rdata),
      .samp(samp), .pwr_out(pwr_out), .zero_flag_left(zero_flag_left), .zero_flag_right(zero_flag_right),
      .internal_divided_clock(internal_divided_clock), .divider_resync(divider_resync));
   // sample strobe every 16 cycles, resync tally, hang guard
   always @(posedge sys_clk) begin
      scnt <= scnt + 4'h1;
      samp <= '{valid: scnt == 4'h0, left: sval, right: sval};
      n_rs <= n_rs + int'(divider_resync);
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         final_report;
      end
   end
   task tick(input int c);
      repeat (c) begin
         @(posedge sys_clk);
         #1;
      end
   endtask
   task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
      @(posedge sys_clk);
      bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      @(posedge sys_clk);
      bus_req <= '0;
      #1;
   endtask
   task rd(input logic [ADDR_W-1:0] a);
      @(posedge sys_clk);
      bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(posedge sys_clk);
      bus_req <= '0;
      #1;
      d = bus_rdata;
   endtask
   // wait at most lim cycles for a watched output to reach v
   task wt(input int sel, input logic v, input int lim);
      logic s;
      n = 0;
      forever begin
         case (sel)
            0: s = pwr_out.internal_reset_n;
            1: s = pwr_out.analog_float;
            2: s = zero_flag_left;
            3: s = divider_resync;
            default: s = pwr_out.digital_run;
         endcase
         if (s === v || n >= lim) break;
         tick(1);
         n++;
      end
   endtask
   task hop;
      jump = 1'b1;
      tick(1);
      jump = 1'b0;
   endtask
   task final_report;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      repeat (8) @(posedge sys_clk);
      rst_b <= 1'b1;
      tick(10);
      rd(REG_CTRL);
      `CHK("ctrl default", CTRL_RST, d)
      rd(4'hF);
      `CHK("unmapped", 16'h0000, d)
      tick(6 * D);
      rd(REG_STAT);
      `CHK("state reset", ST_RESET, d[4:0])
      `CHK("common", 1'b1, pwr_out.analog_common)
      $display("test reset_values done");
      wr(REG_CTRL, 16'h0027);
      wt(0, 1'b1, 4 * D);
      `CHK("release time", 1'b1, n >= 2 * D && n <= 3 * D + 16)
      wt(4, 1'b1, 16);
      rd(REG_STAT);
      `CHK("state normal", ST_NORMAL, d[4:0])
      wt(2, 1'b0, 4 * D);
      sval = 32'h0;
      tick(16);
      wr(REG_CTRL, 16'h0026);
      tick(4);
      `CHK("flags rise", 2'b11, {zero_flag_left, zero_flag_right})
      wt(0, 1'b0, 5 * D);
      `CHK("assert time", 1'b1, n >= 3 * D && n <= 4 * D + 16)
      sval = 32'h1;
      rd(REG_CTRL);
      `CHK("ctrl kept", 16'h0026, d)
      wr(REG_CTRL, 16'h0027);
      wt(0, 1'b1, 4 * D);
      wt(2, 1'b0, 4 * D);
      `CHK("flags fall", 1'b1, n >= 2 * D - 4 && n <= 2 * D + 4)
      $display("test soft_reset done");
      hop;
      wr(REG_CTRL, 16'h0026);
      wt(3, 1'b1, 2 * D);
      `CHK("early resync", 1'b1, n < 2 * D && pwr_out.internal_reset_n === 1'b1)
      wr(REG_CTRL, 16'h0027);
      wt(0, 1'b1, 4 * D);
      $display("test reset_sync done");
      for (int i = 0; i < 3; i++) begin
         wr(REG_CTRL, modes[i]);
         hop;
         sval = 32'h0;
         wt(3, 1'b1, 8 * D);
         m = (int'(phase) + D - edges[i]) % D;
         `CHK("resync edge", 1'b1, n < 8 * D && m >= 2 && m <= 10)
         tick(2);
         k = n_rs;
         tick(3 * D);
         `CHK("no resync", k, n_rs)
         `CHK("zero flags", 2'b11, {zero_flag_left, zero_flag_right})
         rd(REG_STAT);
         `CHK("sync valid", 1'b1, d[9])
         sval = 32'h1;
         tick(56);
         `CHK("run broken", 1'b0, zero_flag_left)
      end
      wr(REG_CTRL, 16'h0023);
      hop;
      sval = 32'h0;
      k = n_rs;
      tick(4 * D);
      `CHK("sync off", k, n_rs)
      $display("test sync done");
      wr(REG_CTRL, 16'h0027);
      tick(2 * D);
      wr(REG_CTRL, 16'h0025);
      wt(1, 1'b1, 6 * D);
      `CHK("off time", 1'b1, n >= 4 * D && n <= 5 * D + 16)
      rd(REG_CTRL);
      `CHK("ctrl in off", 16'h0025, d)
      tick(96);
      `CHK("flags in off", 2'b11, {zero_flag_left, zero_flag_right})
      wr(REG_CTRL, 16'h0027);
      wt(1, 1'b0, 3 * D);
      `CHK("on time", 1'b1, n >= D && n <= 2 * D + 16)
      $display("test power_bit done");
      tick(96);
      stop = 1'b1;
      wt(1, 1'b1, 200);
      `CHK("stop time", 1'b1, n >= 95 && n <= 115)
      `CHK("flags stop", 2'b00, {zero_flag_left, zero_flag_right})
      stop = 1'b0;
      wt(4, 1'b1, 4 * D);
      `CHK("clock back", 1'b1, n < 4 * D)
      sval = 32'h1;
      $display("test clock_stop done");
      wr(REG_CTRL, 16'h00A7);
      tick(3);
      `CHK("flag polarity", 2'b11, {zero_flag_left, zero_flag_right})
      @(posedge sys_clk);
      powerdown_pin_n <= 1'b0;
      tick(10);
      `CHK("pin float", 1'b1, pwr_out.analog_float)
      wr(REG_CTRL, 16'h0027);
      @(posedge sys_clk);
      powerdown_pin_n <= 1'b1;
      tick(10);
      rd(REG_CTRL);
      `CHK("pin default", CTRL_RST, d)
      $display("test pin_down done");
      final_report;
   end
endmodule
